// ### core/das_port.sv
// Function
// RL1: frames stereo samples as I2S, left-justified or right-justified, the last one optional.
// RL2: samples are held as 16-bit words and at most 16 significant bits leave per channel.
// RL3: input words longer than 16 bits are rounded to 16 bits on the 17th bit, except right-justified, which keeps the last 16 bits.
// RL4: the bit clock normally gives 64 cycles per word-select period, 32 per channel.
// RL5: no word-select period may hold fewer than 36 bit-clock cycles.
// RL6: the port shares its pins with the voice interface and only one owns them at a time.
// RL7: master role drives bit clock and word select, slave role accepts both.
// RL8: data in, and word select in slave role, are taken on the bit clock rising edge.
// RL9: data out and master word select are launched on falling edges for the next rise.
// RL10: I2S puts the MSB one bit after word select moves, left-justified on it, right ends on LSB.
`timescale 1ns/1ps
module das_port #(
  parameter bit RIGHT_JUST_EN = 1'b1,
  parameter int FIFO_DEPTH    = das_pkg::FIFO_DEPTH
) (
  input  logic                ref_clk,
  input  logic                rst_n,
  input  logic                audio_pin_sel,
  input  logic                master_sel,
  input  das_pkg::das_fmt_t   fmt,
  input  logic                sck_i,
  output logic                sck_o,
  output logic                sck_oe_n,
  input  logic                ws_i,
  output logic                ws_o,
  output logic                ws_oe_n,
  input  logic                serial_audio_in,
  output logic                serial_audio_out,
  output logic                serial_audio_out_oe_n,
  input  logic                tx_valid,
  output logic                tx_ready,
  input  das_pkg::das_pair_t  tx_data,
  output logic                rx_valid,
  output das_pkg::das_pair_t  rx_data,
  output logic                frame_error
);
  localparam int CW = das_pkg::CNT_W;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  das_pkg::das_pins_t s1_q;
  das_pkg::das_pins_t s2_q;
  logic               sck_prev_q;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q       <= '0;
      s2_q       <= '0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      s1_q       <= '{sck: sck_i, ws: ws_i, sd: serial_audio_in};
      s2_q       <= s1_q;
      sck_prev_q <= s2_q.sck;
    end
  end

  // ************************************************************
  // framing state
  // ************************************************************
  das_pkg::das_pair_t tx_head;
  logic               tx_head_valid;
  logic               pop;

  das_fifo #(
    .WIDTH ($bits(das_pkg::das_pair_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (tx_head_valid),
    .out_ready (pop),
    .out_data  (tx_head)
  );

  logic [CW-1:0]      div_q, div_d, idx_q, idx_d, len_q, len_d;
  logic               msck_q, msck_d, mws_q, mws_d, ws_cur_q, ws_cur_d;
  logic [16:0]        acc_q, acc_d;
  logic [4:0]         n_q, n_d;
  logic [15:0]        sr_q, sr_d, lw_q, lw_d;
  das_pkg::das_pair_t rx_data_q, rx_data_d, cur_q, cur_d;
  logic               rx_valid_q, rx_valid_d, sd_q, sd_d, fe_q, fe_d;
  logic               sck_oe_n_q, ws_oe_n_q, sd_oe_n_q;

  das_pkg::das_fmt_t  fmt_eff;
  das_pkg::das_pair_t pair;
  logic               own, rise_ev, fall_ev, ws_smp, new_half, pos_live, nws;
  logic [CW-1:0]      nidx, len_tx, off;
  logic [15:0]        word;
  logic [16:0]        acc_b;
  logic [4:0]         n_b;
  int                 p;

  // voice interface keeps the pins whenever audio is not selected
  assign own     = audio_pin_sel; // [RL6]
  assign fmt_eff = (fmt == das_pkg::DAS_FMT_RIGHT_JUSTIFIED && !RIGHT_JUST_EN) ? // [RL1]
                   das_pkg::DAS_FMT_I2S : fmt;
  assign rise_ev = own && (master_sel ? (div_q == CW'(das_pkg::SCK_HALF_CYC - 1) && !msck_q)
                                      : (s2_q.sck && !sck_prev_q));
  assign fall_ev = own && (master_sel ? (div_q == CW'(das_pkg::SCK_HALF_CYC - 1) && msck_q)
                                      : (!s2_q.sck && sck_prev_q));
  assign ws_smp  = master_sel ? mws_q : s2_q.ws; // [RL8]

  always_comb
  begin
    div_d = div_q;   msck_d = msck_q;   mws_d = mws_q;   idx_d = idx_q;
    len_d = len_q;   ws_cur_d = ws_cur_q;   acc_d = acc_q;   n_d = n_q;
    sr_d = sr_q;     lw_d = lw_q;   rx_data_d = rx_data_q;   rx_valid_d = 1'b0;
    cur_d = cur_q;   sd_d = sd_q;   fe_d = 1'b0;   pop = 1'b0;   pos_live = 1'b0;
    new_half = 1'b0; pair = cur_q;  word = 16'h0;  p = 0;  acc_b = acc_q;  n_b = n_q;
    off    = (fmt_eff == das_pkg::DAS_FMT_I2S) ? CW'(1) : CW'(0); // [RL10]
    // master frame is fixed, slave frame is learned from the last half
    len_tx = master_sel ? CW'(das_pkg::HALF_BITS) : len_q; // [RL4]
    nidx   = (idx_q >= len_tx - CW'(1)) ? '0 : idx_q + CW'(1);
    nws    = (nidx == '0) ? !ws_cur_q : ws_cur_q;

    if (own && master_sel)
    begin
      div_d = (div_q == CW'(das_pkg::SCK_HALF_CYC - 1)) ? '0 : div_q + CW'(1);
      if (div_q == CW'(das_pkg::SCK_HALF_CYC - 1))
        msck_d = !msck_q; // [RL7]
    end
    else
    begin
      div_d  = '0;
      msck_d = 1'b0;
    end

    if (!own)
    begin
      idx_d = '0;
      sd_d  = 1'b0;
    end

    if (rise_ev)
    begin
      new_half = ws_smp != ws_cur_q;
      sr_d     = {sr_q[14:0], s2_q.sd}; // [RL8]
      ws_cur_d = ws_smp; // [RL8]
      if (new_half)
      begin
        len_d = idx_q + CW'(1);
        // two short halves in a row mean too few clocks per period
        if ({1'b0, len_q} + {1'b0, idx_q} + 1'b1 < (CW+1)'(das_pkg::MIN_FRAME_BITS))
          fe_d = 1'b1; // [RL5]
        word = (fmt_eff == das_pkg::DAS_FMT_RIGHT_JUSTIFIED) ? sr_q // [RL3]
               : das_pkg::das_round(acc_q, n_q);
        if (das_pkg::das_is_left(fmt_eff, ws_cur_q))
          lw_d = word;
        else
        begin
          rx_data_d  = '{left: lw_q, right: word};
          rx_valid_d = 1'b1;
        end
        idx_d = '0;
        acc_b = '0;
        n_b   = '0;
      end
      else
        idx_d = (&idx_q[CW-1:1]) ? idx_q : idx_q + CW'(1);
      // keep only the first 17 bits, the 17th decides the rounding
      if (idx_d >= off && n_b < 5'(das_pkg::ROUND_W))
      begin
        acc_d = {acc_b[15:0], s2_q.sd}; // [RL3]
        n_d   = n_b + 5'd1;
      end
      else
      begin
        acc_d = acc_b;
        n_d   = n_b;
      end
    end

    if (fall_ev)
    begin
      if (master_sel)
        mws_d = nws; // [RL7] [RL9]
      if (nidx == '0 && das_pkg::das_is_left(fmt_eff, nws))
      begin
        // an empty queue sends silence rather than stale audio
        pop   = tx_head_valid;
        pair  = tx_head_valid ? tx_head : '0;
        cur_d = pair;
      end
      word = das_pkg::das_is_left(fmt_eff, nws) ? pair.left : pair.right;
      if (fmt_eff == das_pkg::DAS_FMT_RIGHT_JUSTIFIED)
        p = int'(nidx) - (int'(len_tx) - das_pkg::SAMPLE_W); // [RL10]
      else
        p = int'(nidx) - int'(off); // [RL10]
      pos_live = (p >= 0) && (p < das_pkg::SAMPLE_W);
      sd_d     = pos_live ? word[4'(15 - p)] : 1'b0; // [RL2] [RL9]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= '0;  msck_q <= 1'b0;  mws_q <= 1'b0;  idx_q <= '0;
      len_q <= CW'(das_pkg::HALF_BITS);  ws_cur_q <= 1'b0;  acc_q <= '0;  n_q <= '0;
      sr_q <= '0;  lw_q <= '0;  rx_data_q <= '0;  rx_valid_q <= 1'b0;
      cur_q <= '0;  sd_q <= 1'b0;  fe_q <= 1'b0;
      sck_oe_n_q <= das_pkg::RST_OE_N;
      ws_oe_n_q  <= das_pkg::RST_OE_N;
      sd_oe_n_q  <= das_pkg::RST_OE_N;
    end
    else
    begin
      div_q <= div_d;  msck_q <= msck_d;  mws_q <= mws_d;  idx_q <= idx_d;
      len_q <= len_d;  ws_cur_q <= ws_cur_d;  acc_q <= acc_d;  n_q <= n_d;
      sr_q <= sr_d;  lw_q <= lw_d;  rx_data_q <= rx_data_d;  rx_valid_q <= rx_valid_d;
      cur_q <= cur_d;  sd_q <= sd_d;  fe_q <= fe_d;
      sck_oe_n_q <= !(own && master_sel); // [RL6] [RL7]
      ws_oe_n_q  <= !(own && master_sel); // [RL6] [RL7]
      sd_oe_n_q  <= !own; // [RL6]
    end
  end

  assign sck_o                 = msck_q;
  assign ws_o                  = mws_q;
  assign sck_oe_n              = sck_oe_n_q;
  assign ws_oe_n               = ws_oe_n_q;
  assign serial_audio_out      = sd_q;
  assign serial_audio_out_oe_n = sd_oe_n_q;
  assign rx_valid              = rx_valid_q;
  assign rx_data               = rx_data_q;
  assign frame_error           = fe_q;

  // ************************************************************
  // checks
  // ************************************************************
  logic [CW-1:0] hcnt_q;
  logic          hseen_q;
  logic [15:0]   acc_hi;

  assign acc_hi = acc_q[16:1];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hcnt_q  <= '0;
      hseen_q <= 1'b0;
    end
    else if (!(own && master_sel))
    begin
      hcnt_q  <= '0;
      hseen_q <= 1'b0;
    end
    else if (fall_ev)
    begin
      hcnt_q  <= (mws_d != mws_q) ? '0 : hcnt_q + CW'(1);
      hseen_q <= hseen_q || (mws_d != mws_q);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sck_high;
    sck_o [*4];
  endsequence

  sequence s_sck_low;
    !sck_o [*4];
  endsequence

  property p_sck_period;
    @(posedge ref_clk) disable iff (!rst_n || !audio_pin_sel || !master_sel)
      $rose(sck_o) |-> s_sck_high ##1 s_sck_low ##1 sck_o;
  endproperty

  pin_release_a: assert property ( // [RL6]
    !own |=> sck_oe_n && ws_oe_n && serial_audio_out_oe_n)
    else $error("pins driven while voice interface owns them");
  role_drive_a: assert property ( // [RL7]
    own |=> (sck_oe_n == !$past(master_sel)) && !ws_oe_n == !sck_oe_n)
    else $error("clock and word select drive does not follow role");
  sck_period_a: assert property (p_sck_period) // [RL4]
    else $error("master bit clock period wrong");
  ws_half_a: assert property ( // [RL4]
    fall_ev && own && master_sel && hseen_q && mws_d != mws_q
      |-> hcnt_q == CW'(das_pkg::HALF_BITS - 1))
    else $error("master word select half period is not 32 bit clocks");
  ws_launch_a: assert property ( // [RL9]
    own && master_sel && $changed(ws_o) |-> !sck_o && $past(sck_o))
    else $error("word select changed away from a falling edge");
  sd_launch_a: assert property (own && $changed(serial_audio_out) |-> $past(fall_ev)) // [RL9]
    else $error("serial data changed away from a falling edge");
  pad_silent_a: assert property (fall_ev && !pos_live |=> !serial_audio_out) // [RL2]
    else $error("bit driven outside the 16 bit sample window");
  rx_on_rise_a: assert property ( // [RL8]
    rx_valid |-> $past(rise_ev) && $past(ws_smp) != $past(ws_cur_q))
    else $error("received pair completed away from a rising edge");
  round_step_a: assert property ( // [RL3]
    rise_ev && new_half && n_q == 5'd17 && fmt_eff != das_pkg::DAS_FMT_RIGHT_JUSTIFIED
      && das_pkg::das_is_left(fmt_eff, ws_cur_q) && acc_hi != 16'hFFFF
      |=> lw_q >= $past(acc_hi) && lw_q - $past(acc_hi) <= 16'h1)
    else $error("long word not rounded on its 17th bit");
  short_frame_a: assert property ( // [RL5]
    frame_error |-> $past(len_q) + $past(idx_q) + 1 < das_pkg::MIN_FRAME_BITS)
    else $error("frame error without a short frame");

endmodule : das_port

// ### core/das_pkg.sv
package das_pkg;

  // ************************************************************
  // widths and framing
  // ************************************************************
  localparam int SAMPLE_W       = 16;
  localparam int ROUND_W        = 17;
  localparam int HALF_BITS      = 32;
  localparam int MIN_FRAME_BITS = 36;
  localparam int CNT_W          = 7;
  localparam int FIFO_DEPTH     = 8;
  localparam logic [15:0] SAMPLE_MAX = 16'h7FFF;
  localparam logic        RST_OE_N   = 1'b1;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int REF_PERIOD_NS = 50;
  localparam int SCK_PERIOD_NS = 400;
  localparam int SCK_HALF_CYC  = ((SCK_PERIOD_NS / 2) / REF_PERIOD_NS) < 1 ? 1 :
                                 ((SCK_PERIOD_NS / 2) / REF_PERIOD_NS);

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    DAS_FMT_I2S,
    DAS_FMT_LEFT_JUSTIFIED,
    DAS_FMT_RIGHT_JUSTIFIED
  } das_fmt_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } das_pair_t;

  typedef struct packed {
    logic sck;
    logic ws;
    logic sd;
  } das_pins_t;

  function automatic logic das_is_left(input das_fmt_t f, input logic ws);
    return (f == DAS_FMT_I2S) ? !ws : ws;
  endfunction : das_is_left

  // left-aligns short words, rounds long ones on the 17th bit
  function automatic logic [15:0] das_round(input logic [16:0] acc, input logic [4:0] n);
    logic [15:0] r;
    r = 16'h0;
    if (n >= 5'd17)
      r = (acc[16:1] == SAMPLE_MAX && acc[0]) ? SAMPLE_MAX : acc[16:1] + {15'h0, acc[0]};
    else
      r = acc[15:0] << (5'd16 - n);
    return r;
  endfunction : das_round

endpackage : das_pkg

// ### core/das_fifo.sv
`timescale 1ns/1ps
module das_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  logic             clk,
  input  logic             rst_n,
  input  logic             in_valid,
  output logic             in_ready,
  input  logic [WIDTH-1:0] in_data,
  output logic             out_valid,
  input  logic             out_ready,
  output logic [WIDTH-1:0] out_data
);
  // depth must be a power of two: pointers wrap naturally
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_d;
  logic             push;
  logic             pull;

  always_comb
  begin
    in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    out_valid = wr_q != rd_q;
    push      = in_valid && in_ready;
    pull      = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pull ? rd_q + 1'b1 : rd_q;
  end

  assign out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end

endmodule : das_fifo

// ### testbench/das_codec_model.sv
`timescale 1ns/1ps
// ************************************************************
// far-side converter: clocks frames in slave tests, follows them in master tests
// ************************************************************
module das_codec_model (
  input  logic              sck_line,
  input  logic              ws_line,
  input  logic              sd_dev,
  input  das_pkg::das_fmt_t fmt,
  output logic              sck_q,
  output logic              ws_q,
  output logic              sd_q
);
  logic [23:0] tx_l;
  logic [23:0] tx_r;
  logic [23:0] w;
  logic [15:0] rx_l;
  logic [15:0] rx_r;
  logic [15:0] rx_tail;
  logic [63:0] sh;
  logic        ws_prev;
  logic        ws_tx;
  int          nbits;
  int          half;
  int          idx;
  int          tidx;
  int          msb;
  int          k;
  int          last_half;
  int          halves;

  initial
  begin
    {sck_q, ws_q, sd_q, ws_prev, ws_tx} = 5'h0;
    {tx_l, tx_r, sh} = '0;
    {rx_l, rx_r, rx_tail} = '0;
    nbits = 16;
    half = 32;
    {idx, tidx, last_half, halves} = '0;
  end

  // clock stands low between calls; ws moves on the falling edge
  task automatic frames(input int n, input int hb);
    for (int i = 0; i < 2 * n * hb; i++)
    begin
      sck_q = 1'b0;
      if (i % hb == 0) ws_q = ~ws_q;
      #200;
      sck_q = 1'b1;
      #200;
    end
    sck_q = 1'b0;
  endtask : frames

  function automatic logic [15:0] grab();
    if (idx < 17) return 16'h0;
    case (fmt)
      das_pkg::DAS_FMT_I2S: return sh[idx-2 -: 16];
      das_pkg::DAS_FMT_LEFT_JUSTIFIED: return sh[idx-1 -: 16];
      default:              return sh[15:0];
    endcase
  endfunction : grab

  // launch after the fall so the far end sees it settled at the rise
  always @(negedge sck_line)
  begin
    #5;
    tidx = (ws_line !== ws_tx) ? 0 : tidx + 1;
    ws_tx = ws_line;
    msb = (fmt == das_pkg::DAS_FMT_I2S) ? 1 :
          (fmt == das_pkg::DAS_FMT_LEFT_JUSTIFIED) ? 0 : half - nbits;
    w = ((fmt == das_pkg::DAS_FMT_I2S) ? !ws_line : ws_line) ? tx_l : tx_r;
    k = tidx - msb;
    sd_q = (k >= 0 && k < nbits) ? w[nbits-1-k] : 1'b0;
  end

  always @(posedge sck_line)
  begin
    if (ws_line !== ws_prev)
    begin
      if ((fmt == das_pkg::DAS_FMT_I2S) ? !ws_prev : ws_prev) rx_l = grab();
      else rx_r = grab();
      rx_tail = (fmt == das_pkg::DAS_FMT_LEFT_JUSTIFIED) ? sh[15:0] : 16'h0;
      last_half = idx;
      halves++;
      idx = 0;
    end
    sh = {sh[62:0], sd_dev};
    idx++;
    ws_prev = ws_line;
  end
endmodule : das_codec_model

// ### testbench/digital_audio_serial_bus_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module digital_audio_serial_bus_tb;
  logic               ref_clk;
  logic               rst_n;
  logic               audio_pin_sel;
  logic               master_sel;
  logic               tx_valid;
  logic               sck_o, sck_oe_n, ws_o, ws_oe_n, sd_o, sd_oe_n;
  logic               tx_ready, rx_valid, frame_error, c_sck, c_ws, c_sd;
  das_pkg::das_fmt_t  fmt;
  das_pkg::das_pair_t tx_data, rx_data, rx_last;
  int                 fails = 0;
  int                 checked = 0;
  int                 ferr_cnt = 0;
  // released lines fall to the pull-down level
  wire sck_l = !sck_oe_n ? sck_o : (!master_sel ? c_sck : 1'b0);
  wire ws_l  = !ws_oe_n ? ws_o : (!master_sel ? c_ws : 1'b0);
  wire sd_l  = !sd_oe_n ? sd_o : 1'b0;

  das_port dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .audio_pin_sel(audio_pin_sel),
    .master_sel(master_sel), .fmt(fmt), .sck_i(sck_l), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
    .ws_i(ws_l), .ws_o(ws_o), .ws_oe_n(ws_oe_n), .serial_audio_in(c_sd),
    .serial_audio_out(sd_o), .serial_audio_out_oe_n(sd_oe_n), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
    .frame_error(frame_error));
  das_codec_model cm (.sck_line(sck_l), .ws_line(ws_l), .sd_dev(sd_l), .fmt(fmt),
    .sck_q(c_sck), .ws_q(c_ws), .sd_q(c_sd));

  always @(posedge ref_clk)
  begin
    if (rx_valid === 1'b1) rx_last <= rx_data;
    if (frame_error === 1'b1) ferr_cnt++;
  end

  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic wait_halves(input int k);
    int target;
    int n;
    target = cm.halves + k;
    n = 0;
    while (cm.halves < target && n < k * 700)
    begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(cm.halves >= target, 1'b1)
  endtask : wait_halves

  task automatic t_reset;
    repeat (2) @(negedge ref_clk);
    `CHK({sck_oe_n, ws_oe_n, sd_oe_n}, 3'b111)
    `CHK({tx_ready, rx_valid, frame_error}, 3'b100)
  endtask : t_reset

  task automatic t_slave;
    for (int f = 0; f < 3; f++)
    begin
      @(negedge ref_clk);
      audio_pin_sel = 1'b1;
      fmt = das_pkg::das_fmt_t'(f);
      cm.tx_l = 24'h008001 + 24'(f);
      cm.tx_r = 24'h007F10 + 24'(f);
      cm.frames(3, 32);
      repeat (8) @(negedge ref_clk);
      `CHK(rx_last, {16'h8001 + 16'(f), 16'h7F10 + 16'(f)})
      `CHK({sck_oe_n, ws_oe_n}, 2'b11)
    end
  endtask : t_slave

  task automatic t_round;
    @(negedge ref_clk);
    fmt = das_pkg::DAS_FMT_I2S;
    cm.tx_l = 24'h123480;
    cm.tx_r = 24'h7FFFFF;
    cm.nbits = 24;
    cm.frames(3, 32);
    repeat (8) @(negedge ref_clk);
    `CHK(rx_last, 32'h12357FFF)
    cm.nbits = 16;
    ferr_cnt = 0;
    cm.frames(2, 18);
    `CHK(ferr_cnt, 0)
    cm.frames(2, 16);
    repeat (8) @(negedge ref_clk);
    `CHK(ferr_cnt > 0, 1'b1)
  endtask : t_round

  // fill the buffer while the pins are released, then let master frames drain it dry
  task automatic t_master;
    das_pkg::das_pair_t p;
    int                 n;
    for (int f = 0; f < 3; f++)
    begin
      p = {16'hC3A0 + 16'(f), 16'h1E5F + 16'(f)};
      @(negedge ref_clk);
      audio_pin_sel = 1'b0;
      master_sel = 1'b1;
      fmt = das_pkg::das_fmt_t'(f);
      cm.tx_l = 24'h00B00F + 24'(f);
      cm.tx_r = 24'h004C71;
      repeat (3) @(negedge ref_clk);
      `CHK({sck_oe_n, ws_oe_n, sd_oe_n}, 3'b111)
      tx_data = p;
      tx_valid = 1'b1;
      n = 0;
      while (tx_ready === 1'b1 && n < 20)
      begin
        @(negedge ref_clk);
        n++;
      end
      tx_valid = 1'b0;
      `CHK(n, 8)
      audio_pin_sel = 1'b1;
      wait_halves(8);
      `CHK({sck_oe_n, ws_oe_n, sd_oe_n}, 3'b000)
      `CHK({cm.rx_l, cm.rx_r}, p)
      `CHK(cm.last_half, 32)
      `CHK(rx_last, {cm.tx_l[15:0], cm.tx_r[15:0]})
      if (f == 1) `CHK(cm.rx_tail, 16'h0)
      wait_halves(18);
      `CHK({cm.rx_l, cm.rx_r}, 32'h0)
    end
  endtask : t_master

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // whole run is near 30k cycles; cut off at twice that
  initial
  begin
    #3_000_000;
    fails++;
    close_out();
  end

  initial
  begin
    {rst_n, audio_pin_sel, master_sel, tx_valid} = 4'h0;
    fmt = das_pkg::DAS_FMT_I2S;
    tx_data = '0;
    rx_last = '0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_slave();
    t_round();
    t_master();
    close_out();
  end
endmodule : digital_audio_serial_bus_tb
